// >>> hdl/flash_prot_pkg.sv
/*
  Constants and types shared by the flash block protection controller:
  block geometry, protection levels, register offsets, field positions,
  reset values and commit sequencer states.
  Assumes a 32-bit Wishbone register bus and a 50 MHz system clock.
*/
package flash_prot_pkg;

  // Flash geometry: 64 blocks of 2 kB
  localparam int FLASH_BLOCKS = 64;
  localparam int BLK_W = 6;
  localparam int BLOCK_SHIFT = 11;
  localparam int FLASH_ADDR_W = 17;

  // Codes are ordered by strictness, so a larger code is a tighter level
  typedef enum logic [1:0] {
    level_full_access = 2'h0,
    level_no_modify = 2'h1,
    level_fetch_only = 2'h2
  } level_t;
  localparam logic [1:0] LEVEL_UNDEFINED = 2'h3;

  // Access kinds presented on the access check port
  localparam logic [1:0] ACC_FETCH = 2'h0;
  localparam logic [1:0] ACC_READ = 2'h1;
  localparam logic [1:0] ACC_ERASE = 2'h2;
  localparam logic [1:0] ACC_PROGRAM = 2'h3;

  // Register byte offsets
  localparam logic [7:0] PROT_ADDR_OFS = 8'h00;
  localparam logic [7:0] PROT_LEVEL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] COMMIT_OFS = 8'h0c;
  localparam logic [7:0] USEC_OFS = 8'h10;
  localparam logic [7:0] USER0_OFS = 8'h14;
  localparam logic [7:0] USER1_OFS = 8'h18;
  localparam logic [7:0] INT_RAW_OFS = 8'h1c;
  localparam logic [7:0] INT_MASK_OFS = 8'h20;
  localparam logic [7:0] INT_MSK_STAT_OFS = 8'h24;
  localparam logic [7:0] INT_CLEAR_OFS = 8'h28;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_SET_FAIL = 1;
  localparam int ST_COMMIT_OK = 2;
  localparam int ST_COMMIT_ERR = 3;

  // Commit command fields
  localparam int CMD_PROT = 0;
  localparam int CMD_USER = 1;

  // Interrupt source bits
  localparam int operation_done_source = 0;
  localparam int access_violation_source = 1;

  // Reset values
  localparam logic [7:0] USEC_RESET = 8'h32;
  localparam logic [31:0] USER_RESET = 32'hffffffff;

  // Commit sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_WRITE = 3'b010,
    SEQ_FINISH = 3'b100
  } seq_state_t;

endpackage

// >>> hdl/commit_if.sv
/*
  Handshake between the protection controller and its commit sequencer.
  Assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ps
interface commit_if;
  logic start;
  logic to_user;
  logic busy;
  logic done;
  logic fail;

  modport ctrl (output start, output to_user, input busy, input done, input fail);
  modport seq (input start, input to_user, output busy, output done, output fail);
endinterface

// >>> hdl/commit_seq.sv
/*
  Commit sequencer: drives one write request to the non-volatile
  configuration store and reports its outcome as a one-cycle done pulse.
  Assumes the store holds ack high for one cycle when it finishes and
  samples the image ports while the request is high.
*/
`timescale 1ns/1ps
module commit_seq
  import flash_prot_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controller side
  commit_if.seq cmt,
  // Non-volatile store side
  output logic nv_req,
  output logic nv_sel_user,
  input wire logic nv_ack,
  input wire logic nv_err
);

  seq_state_t state_r, state_nxt;
  logic sel_r, sel_nxt;
  logic fail_r, fail_nxt;

  always_comb
  begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    fail_nxt = fail_r;
    case (state_r)
      SEQ_IDLE:
      begin
        if (cmt.start)
        begin
          state_nxt = SEQ_WRITE;
          sel_nxt = cmt.to_user;
        end
      end
      SEQ_WRITE:
      begin
        if (nv_ack)
        begin
          state_nxt = SEQ_FINISH;
          fail_nxt = nv_err;
        end
      end
      SEQ_FINISH:
        state_nxt = SEQ_IDLE;
      default:
        state_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SEQ_IDLE;
      sel_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      fail_r <= fail_nxt;
    end
  end

  // Requester waits on busy until the outcome is known
  assign cmt.busy = (state_r != SEQ_IDLE);
  assign cmt.done = (state_r == SEQ_FINISH);
  assign cmt.fail = fail_r;
  assign nv_req = (state_r == SEQ_WRITE);
  assign nv_sel_user = sel_r;

endmodule

// >>> hdl/flash_block_protection_ctrl.sv
/*
  Flash block protection and configuration controller with a Wishbone
  classic slave. Holds per-block levels, checks flash accesses, commits
  levels and user words to a non-volatile store, times program/erase.
  Assumes the non-volatile store presents its committed image at all times.
*/
`timescale 1ns/1ps
module flash_block_protection_ctrl
  import flash_prot_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Flash access check
  input wire logic ACC_VALID,
  input wire logic [31:0] ACC_ADDR,
  input wire logic [1:0] ACC_KIND,
  output logic ACC_OK,
  // Program/erase engine
  input wire logic OP_DONE,
  output logic USEC_TICK,
  // Non-volatile configuration store
  input wire logic [2*FLASH_BLOCKS-1:0] NV_PROT_IN,
  input wire logic [31:0] NV_USER0_IN,
  input wire logic [31:0] NV_USER1_IN,
  output logic [2*FLASH_BLOCKS-1:0] NV_PROT_OUT,
  output logic [31:0] NV_USER0_OUT,
  output logic [31:0] NV_USER1_OUT,
  output logic NV_REQ,
  output logic NV_SEL_USER,
  input wire logic NV_ACK,
  input wire logic NV_ERR,
  // Interrupt
  output logic FLASH_IRQ
);

  function automatic logic [BLK_W-1:0] blk_of(input logic [31:0] addr);
    return addr[BLOCK_SHIFT +: BLK_W];
  endfunction

  function automatic logic in_flash(input logic [31:0] addr);
    return (addr[31:FLASH_ADDR_W] == '0);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[8*b +: 8] = wdat[8*b +: 8];
    return res;
  endfunction

  commit_if cmt ();

  logic [1:0] prot_r [FLASH_BLOCKS];
  logic [1:0] prot_nxt [FLASH_BLOCKS];
  logic [31:0] prot_addr_r, prot_addr_nxt;
  logic [31:0] user0_r, user0_nxt;
  logic [31:0] user1_r, user1_nxt;
  logic [7:0] usec_r, usec_nxt;
  logic [7:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic loaded_r, loaded_nxt;
  logic set_fail_r, set_fail_nxt;
  logic commit_ok_r, commit_ok_nxt;
  logic commit_err_r, commit_err_nxt;
  logic start_r, start_nxt;
  logic to_user_r, to_user_nxt;
  logic [1:0] int_raw_r, int_raw_nxt;
  logic [1:0] int_mask_r, int_mask_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;

  logic busy;
  logic violation;
  logic wr_fire;
  logic [1:0] acc_level;
  logic [1:0] sel_level;
  logic [1:0] new_code;
  logic [1:0] int_set;
  logic [1:0] int_clr;

  commit_seq u_seq (
    .clk(CLOCK),
    .rst_n(RST_N),
    .cmt(cmt),
    .nv_req(NV_REQ),
    .nv_sel_user(NV_SEL_USER),
    .nv_ack(NV_ACK),
    .nv_err(NV_ERR)
  );

  assign cmt.start = start_r;
  assign cmt.to_user = to_user_r;

  // Level, commit and user word writes are locked out during a commit and until the committed image is back in place
  assign busy = cmt.busy | start_r | !loaded_r;
  assign wr_fire = WB_CYC_I & WB_STB_I & WB_WE_I & ack_r;
  assign acc_level = prot_r[blk_of(ACC_ADDR)];
  assign sel_level = prot_r[blk_of(prot_addr_r)];
  assign new_code = WB_DAT_I[1:0];

  // Out-of-range accesses are not ours to police
  always_comb
  begin
    violation = 1'b0;
    if (ACC_VALID && in_flash(ACC_ADDR))
    begin
      case (ACC_KIND)
        ACC_FETCH: violation = 1'b0;
        ACC_READ: violation = (acc_level == level_fetch_only);
        default: violation = (acc_level != level_full_access);
      endcase
    end
  end
  assign ACC_OK = !violation;

  always_comb
  begin
    int_set = '0;
    int_set[access_violation_source] = violation;
    int_set[operation_done_source] = OP_DONE;
    int_clr = '0;
    if (wr_fire && WB_ADR_I == INT_CLEAR_OFS)
      int_clr = WB_DAT_I[1:0];
  end

  always_comb
  begin
    prot_nxt = prot_r;
    prot_addr_nxt = prot_addr_r;
    user0_nxt = user0_r;
    user1_nxt = user1_r;
    usec_nxt = usec_r;
    loaded_nxt = 1'b1;
    set_fail_nxt = set_fail_r;
    commit_ok_nxt = commit_ok_r;
    commit_err_nxt = commit_err_r;
    start_nxt = 1'b0;
    to_user_nxt = to_user_r;
    int_mask_nxt = int_mask_r;
    // A new event wins over a clear in the same cycle
    int_raw_nxt = (int_raw_r & ~int_clr) | int_set;
    ack_nxt = WB_CYC_I & WB_STB_I & !ack_r;
    rdat_nxt = rdat_r;

    // Restore committed image after every reset
    if (!loaded_r)
    begin
      for (int i = 0; i < FLASH_BLOCKS; i++)
        prot_nxt[i] = NV_PROT_IN[2*i +: 2];
      user0_nxt = NV_USER0_IN;
      user1_nxt = NV_USER1_IN;
    end

    if (cmt.done)
    begin
      commit_ok_nxt = !cmt.fail;
      commit_err_nxt = cmt.fail;
    end

    if (wr_fire)
    begin
      case (WB_ADR_I)
        PROT_ADDR_OFS: prot_addr_nxt = merge(prot_addr_r, WB_DAT_I, WB_SEL_I);
        PROT_LEVEL_OFS:
        begin
          if (!busy && in_flash(prot_addr_r) && new_code != LEVEL_UNDEFINED
              && sel_level != level_fetch_only
              && new_code >= sel_level)
          begin
            prot_nxt[blk_of(prot_addr_r)] = new_code;
            set_fail_nxt = 1'b0;
          end
          else
            set_fail_nxt = 1'b1;
        end
        COMMIT_OFS:
        begin
          if (!busy && (WB_DAT_I[CMD_PROT] || WB_DAT_I[CMD_USER]))
          begin
            start_nxt = 1'b1;
            to_user_nxt = !WB_DAT_I[CMD_PROT];
            commit_ok_nxt = 1'b0;
            commit_err_nxt = 1'b0;
          end
        end
        USEC_OFS: usec_nxt = WB_SEL_I[0] ? WB_DAT_I[7:0] : usec_r;
        USER0_OFS:
        begin
          if (!busy)
            user0_nxt = merge(user0_r, WB_DAT_I, WB_SEL_I);
        end
        USER1_OFS:
        begin
          if (!busy)
            user1_nxt = merge(user1_r, WB_DAT_I, WB_SEL_I);
        end
        INT_MASK_OFS: int_mask_nxt = WB_DAT_I[1:0];
        default: ;
      endcase
    end

    if (ack_nxt)
    begin
      rdat_nxt = '0;
      case (WB_ADR_I)
        PROT_ADDR_OFS: rdat_nxt = prot_addr_r;
        PROT_LEVEL_OFS: rdat_nxt[1:0] = sel_level;
        STATUS_OFS:
        begin
          rdat_nxt[ST_BUSY] = busy;
          rdat_nxt[ST_SET_FAIL] = set_fail_r;
          rdat_nxt[ST_COMMIT_OK] = commit_ok_r;
          rdat_nxt[ST_COMMIT_ERR] = commit_err_r;
        end
        USEC_OFS: rdat_nxt[7:0] = usec_r;
        USER0_OFS: rdat_nxt = user0_r;
        USER1_OFS: rdat_nxt = user1_r;
        INT_RAW_OFS: rdat_nxt[1:0] = int_raw_r;
        INT_MASK_OFS: rdat_nxt[1:0] = int_mask_r;
        INT_MSK_STAT_OFS: rdat_nxt[1:0] = int_raw_r & int_mask_r;
        default: rdat_nxt = '0;
      endcase
    end
  end

  // Microsecond tick for program/erase pulse timing; reads never use it
  always_comb
  begin
    tick_cnt_nxt = tick_cnt_r;
    tick_nxt = 1'b0;
    if (usec_r == 8'h00)
      tick_cnt_nxt = 8'h00;
    else if (tick_cnt_r >= usec_r - 8'h01)
    begin
      tick_cnt_nxt = 8'h00;
      tick_nxt = 1'b1;
    end
    else
      tick_cnt_nxt = tick_cnt_r + 8'h01;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < FLASH_BLOCKS; i++)
        prot_r[i] <= level_full_access;
      prot_addr_r <= '0;
      user0_r <= USER_RESET;
      user1_r <= USER_RESET;
      usec_r <= USEC_RESET;
      tick_cnt_r <= 8'h00;
      tick_r <= 1'b0;
      loaded_r <= 1'b0;
      set_fail_r <= 1'b0;
      commit_ok_r <= 1'b0;
      commit_err_r <= 1'b0;
      start_r <= 1'b0;
      to_user_r <= 1'b0;
      int_raw_r <= 2'h0;
      int_mask_r <= 2'h0;
      ack_r <= 1'b0;
      rdat_r <= '0;
    end
    else
    begin
      prot_r <= prot_nxt;
      prot_addr_r <= prot_addr_nxt;
      user0_r <= user0_nxt;
      user1_r <= user1_nxt;
      usec_r <= usec_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      loaded_r <= loaded_nxt;
      set_fail_r <= set_fail_nxt;
      commit_ok_r <= commit_ok_nxt;
      commit_err_r <= commit_err_nxt;
      start_r <= start_nxt;
      to_user_r <= to_user_nxt;
      int_raw_r <= int_raw_nxt;
      int_mask_r <= int_mask_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  always_comb
  begin
    for (int i = 0; i < FLASH_BLOCKS; i++)
      NV_PROT_OUT[2*i +: 2] = prot_r[i];
  end

  assign NV_USER0_OUT = user0_r;
  assign NV_USER1_OUT = user1_r;
  assign USEC_TICK = tick_r;
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;
  assign FLASH_IRQ = |(int_raw_r & int_mask_r);

endmodule

// >>> tb/prot_monitor.sv
/* Port checker for the flash protection controller.
   Assumes it is bound to the controller top and sees one clock. */
`timescale 1ns/1ps
module prot_monitor
  import flash_prot_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Watched ports
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic ACC_VALID,
  input wire logic [31:0] ACC_ADDR,
  input wire logic [1:0] ACC_KIND,
  input wire logic ACC_OK,
  input wire logic USEC_TICK,
  input wire logic NV_REQ,
  input wire logic NV_ACK
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_wait;
    NV_REQ && !NV_ACK;
  endsequence
  sequence s_done;
    NV_REQ && NV_ACK;
  endsequence
  a_ack_follows: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_idle_ok: assert property (!ACC_VALID |-> ACC_OK)
    else $error("idle refused");
  a_fetch_ok: assert property (ACC_VALID && ACC_KIND == ACC_FETCH |-> ACC_OK)
    else $error("fetch refused");
  a_outside_ok: assert property (ACC_VALID && ACC_ADDR[31:17] != 15'h0 |-> ACC_OK)
    else $error("outside refused");
  a_req_holds: assert property (s_wait |=> NV_REQ)
    else $error("request dropped");
  a_req_ends: assert property (s_done |=> !NV_REQ)
    else $error("request stuck");
  a_tick_pulse: assert property (USEC_TICK |=> !USEC_TICK)
    else $error("tick too long");
endmodule

bind flash_block_protection_ctrl prot_monitor i_prot_monitor (
  .CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR),
  .ACC_KIND(ACC_KIND), .ACC_OK(ACC_OK), .USEC_TICK(USEC_TICK), .NV_REQ(NV_REQ),
  .NV_ACK(NV_ACK));

// >>> tb/nv_store_model.sv
/* Behavioural non-volatile configuration store.
   Assumes one request at a time; keeps its image across resets. */
`timescale 1ns/1ps
module nv_store_model
  import flash_prot_pkg::*;
#(
  parameter int DELAY = 12
)
(
  // Clock
  input wire logic clk,
  // Controller side
  input wire logic req,
  input wire logic sel_user,
  input wire logic fail,
  input wire logic [2*FLASH_BLOCKS-1:0] prot_w,
  input wire logic [31:0] u0_w,
  input wire logic [31:0] u1_w,
  output logic [2*FLASH_BLOCKS-1:0] prot_r = '0,
  output logic [31:0] u0_r = 32'h0,
  output logic [31:0] u1_r = 32'h0,
  output logic ack = 1'b0,
  output logic err = 1'b0
);
  int cnt = 0;
  // No reset: the image must outlive every chip reset
  always @(posedge clk)
  begin
    ack <= 1'b0;
    err <= 1'b0;
    if (req && !ack)
    begin
      cnt <= cnt + 1;
      if (cnt == DELAY)
      begin
        cnt <= 0;
        ack <= 1'b1;
        err <= fail;
        if (!fail && sel_user)
        begin
          u0_r <= u0_w;
          u1_r <= u1_w;
        end
        if (!fail && !sel_user)
          prot_r <= prot_w;
      end
    end
  end
endmodule

// >>> tb/testbench.sv
/* Self-checking bench for the flash protection controller.
   Assumes the store model and the bound port checker. */
`timescale 1ns/1ps
module testbench;
  import flash_prot_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] bsel = 4'hf;
  logic acc_v = 1'b0;
  logic [31:0] acc_a = 32'h0;
  logic [1:0] acc_k = 2'h0;
  logic op_done = 1'b0;
  logic nv_fail = 1'b0;
  logic [31:0] rdat, u0_o, u1_o, u0_i, u1_i;
  logic [2*FLASH_BLOCKS-1:0] p_o, p_i;
  logic ack, acc_ok, tick, req, sel_u, nv_ack, nv_err, irq;
  int lvl[64] = '{default: 0};
  int clv[64] = '{default: 0};
  logic [31:0] u0 = 32'h0, u1 = 32'h0, cu0 = 32'h0, cu1 = 32'h0;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  always #10 CLOCK = ~CLOCK;

  flash_block_protection_ctrl i_flash_block_protection_ctrl (
    .CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(bsel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .ACC_VALID(acc_v), .ACC_ADDR(acc_a), .ACC_KIND(acc_k), .ACC_OK(acc_ok),
    .OP_DONE(op_done), .USEC_TICK(tick), .NV_PROT_IN(p_i), .NV_USER0_IN(u0_i),
    .NV_USER1_IN(u1_i), .NV_PROT_OUT(p_o), .NV_USER0_OUT(u0_o), .NV_USER1_OUT(u1_o),
    .NV_REQ(req), .NV_SEL_USER(sel_u), .NV_ACK(nv_ack), .NV_ERR(nv_err), .FLASH_IRQ(irq));
  nv_store_model i_nv_store_model (
    .clk(CLOCK), .req(req), .sel_user(sel_u), .fail(nv_fail), .prot_w(p_o),
    .u0_w(u0_o), .u1_w(u1_o), .prot_r(p_i), .u0_r(u0_i), .u1_r(u1_i),
    .ack(nv_ack), .err(nv_err));

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge CLOCK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge CLOCK);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge CLOCK); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic irq_is(input logic e);
    @(negedge CLOCK);
    chk(irq, e);
  endtask

  task automatic get_lvl(input int b);
    wr(PROT_ADDR_OFS, b << BLOCK_SHIFT);
    rdm(PROT_LEVEL_OFS, 32'h3, lvl[b]);
  endtask

  task automatic set_lvl(input int b, input int c, input bit busy);
    bit ok;
    ok = !busy && c != 3 && lvl[b] != 2 && c >= lvl[b];
    wr(PROT_ADDR_OFS, b << BLOCK_SHIFT);
    wr(PROT_LEVEL_OFS, c);
    if (ok)
      lvl[b] = c;
    rdm(STATUS_OFS, 32'h2, {30'h0, !ok, 1'b0});
    get_lvl(b);
  endtask

  task automatic commit(input logic [31:0] cmd, input logic f);
    logic [31:0] q;
    nv_fail <= f;
    wr(COMMIT_OFS, cmd);
    set_lvl(0, 2, 1);
    do wb(1'b0, STATUS_OFS, 32'h0, q); while (q[ST_BUSY] !== 1'b0);
    chk(q & 32'hc, f ? 32'h8 : 32'h4);
    if (!f && cmd[CMD_PROT])
      clv = lvl;
    if (!f && cmd[1:0] == 2'h2)
    begin
      cu0 = u0;
      cu1 = u1;
    end
  endtask

  task automatic sweep;
    bit ok;
    bit viol;
    viol = 0;
    wr(INT_CLEAR_OFS, 32'h3);
    for (int b = 0; b < FLASH_BLOCKS; b++)
      for (int k = 0; k < 4; k++)
      begin
        ok = k == ACC_FETCH || (k == ACC_READ && lvl[b] != 2) || lvl[b] == 0;
        viol |= !ok;
        @(posedge CLOCK);
        acc_v <= 1'b1;
        acc_a <= (b << BLOCK_SHIFT) | $urandom_range(2047, 0);
        acc_k <= k[1:0];
        @(negedge CLOCK);
        chk(acc_ok, ok);
      end
    @(posedge CLOCK);
    acc_a <= 32'h00020000 | (32'h1 << BLOCK_SHIFT);
    acc_k <= ACC_READ;
    @(negedge CLOCK);
    chk(acc_ok, 1'b1);
    @(posedge CLOCK);
    acc_v <= 1'b0;
    rdm(INT_RAW_OFS, 32'h2, {30'h0, viol, 1'b0});
  endtask

  task automatic rst;
    RST_N <= 1'b0;
    repeat (12) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    lvl = clv;
    u0 = cu0;
    u1 = cu1;
  endtask

  initial
  begin
    logic [31:0] v;
    int n;
    void'($urandom(32'ha9d2));
    rst();
    rdm(USEC_OFS, 32'hff, 32'h32);
    v = $urandom_range(40, 3);
    wr(USEC_OFS, v);
    rdm(USEC_OFS, 32'hff, v);
    do @(posedge CLOCK); while (tick !== 1'b1);
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n++;
    end
    while (tick !== 1'b1);
    chk(n, v);
    set_lvl(1, 2, 0);
    set_lvl(1, 0, 0);
    set_lvl(2, 1, 0);
    set_lvl(2, 0, 0);
    set_lvl(3, 3, 0);
    repeat (24) set_lvl($urandom_range(7, 0), $urandom_range(3, 0), 0);
    sweep();
    wr(INT_MASK_OFS, 32'h2);
    irq_is(1'b1);
    rdm(INT_MSK_STAT_OFS, 32'h3, 32'h2);
    wr(INT_CLEAR_OFS, 32'h2);
    rdm(INT_RAW_OFS, 32'h3, 32'h0);
    @(posedge CLOCK);
    op_done <= 1'b1;
    @(posedge CLOCK);
    op_done <= 1'b0;
    rdm(INT_RAW_OFS, 32'h3, 32'h1);
    irq_is(1'b0);
    wr(INT_MASK_OFS, 32'h1);
    irq_is(1'b1);
    wr(INT_CLEAR_OFS, 32'h1);
    irq_is(1'b0);
    u0 = $urandom;
    u1 = $urandom;
    wr(USER0_OFS, u0);
    wr(USER1_OFS, u1);
    bsel <= 4'h6;
    wr(USER1_OFS, ~u1);
    bsel <= 4'hf;
    u1 = {u1[31:24], ~u1[23:8], u1[7:0]};
    rdm(USER0_OFS, '1, u0);
    rdm(USER1_OFS, '1, u1);
    commit(1, 1'b1);
    commit(1, 1'b0);
    commit(2, 1'b0);
    set_lvl(4, 1, 0);
    commit(3, 1'b0);
    set_lvl(4, 2, 0);
    u0 = ~u0;
    wr(USER0_OFS, u0);
    rst();
    for (int b = 0; b < 8; b++) get_lvl(b);
    rdm(USER0_OFS, '1, u0);
    rdm(USER1_OFS, '1, u1);
    rdm(USEC_OFS, 32'hff, 32'h32);
    final_report();
  end
endmodule
